// ---- hw/tsc_consts.svh ----
// Purpose: Constants of the tracker serial command parser.
// Assumes: Included by its bare name after the package.
// Notes:   Byte offsets are Avalon-MM byte addresses.
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH
`define TSC_CLK_HZ       125000000
`define TSC_BAUD_3D      19200
`define TSC_BAUD_2D      1200
`define TSC_BIT_CYC_3D   (`TSC_CLK_HZ / `TSC_BAUD_3D)
`define TSC_BIT_CYC_2D   (`TSC_CLK_HZ / `TSC_BAUD_2D)
`define TSC_REFRESH_MS   20
`define TSC_REFRESH_CYC  (`TSC_CLK_HZ / 1000 * `TSC_REFRESH_MS)
`define TSC_NBITS_3D     4'h8
`define TSC_NBITS_2D     4'h7
`define TSC_STAR         8'h2a
`define TSC_CMD_TO_2D    8'h3c
`define TSC_CMD_RESET    8'h52
`define TSC_CMD_DEMAND   8'h44
`define TSC_CMD_SINGLE   8'h64
`define TSC_CMD_INCR     8'h49
`define TSC_CMD_STREAM   8'h53
`define TSC_CMD_DIAG     8'h05
`define TSC_CMD_SPK_ON   8'h41
`define TSC_CMD_SPK_OFF  8'h4f
`define TSC_CMD_INFO     8'h6d
`define TSC_LEN_DIAG     5'h02
`define TSC_LEN_INFO     5'h1e
`define TSC_LEN_REPORT   5'h10
`define TSC_RM_INCR      3'h1
`define TSC_RM_DEMAND    3'h2
`define TSC_RM_STREAM    3'h4
`define TSC_DIM_3D       8'h02
`define TSC_DATA_TYPE    8'h01
`define TSC_REC_SIZE     8'h10
`define TSC_TRACK_MODE   8'h01
`define TSC_OFF_STATUS   8'h00
`define TSC_OFF_DIAG     8'h04
`define TSC_OFF_INFO     8'h08
`define TSC_OFF_SPAN0    8'h0c
`define TSC_OFF_SPAN1    8'h10
`define TSC_OFF_SPAN2    8'h14
`define TSC_DIAG_RST     8'hff
`define TSC_INFO_RST     32'h020f0f3f
`endif

// ---- hw/tsc_pkg.sv ----
// Purpose: Types of the tracker serial command parser.
// Assumes: Single clock domain.
// Notes:   The first item of each enum is its reset value.
package tsc_pkg;
  typedef logic [127:0] tsc_report_type;
  typedef enum logic [1:0] {TSC_DEMAND, TSC_INCR, TSC_STREAM}
    tsc_mode_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
    tsc_rx_type;
  typedef enum logic [1:0] {RESP_NONE, RESP_DIAG, RESP_INFO, RESP_REPORT}
    tsc_resp_type;
  typedef struct packed {
    logic           rx_s1;
    logic           rx_s2;
    tsc_rx_type     rx_st;
    logic [23:0]    rx_cnt;
    logic [3:0]     rx_bit;
    logic [7:0]     rx_sh;
    logic           got_star;
    tsc_mode_type   mode;
    logic           spk_on;
    logic           dim_2d;
    logic           sw_rst;
    logic [23:0]    tick_cnt;
    tsc_report_type held;
    tsc_resp_type   resp;
    logic [4:0]     idx;
    logic           tx_busy;
    logic           tx_line;
    logic [8:0]     tx_sh;
    logic [3:0]     tx_bits;
    logic [23:0]    tx_cnt;
    logic           waitreq;
    logic [31:0]    rdata;
    logic [7:0]     diag;
    logic [31:0]    info;
    logic [31:0]    span0;
    logic [31:0]    span1;
    logic [31:0]    span2;
  } tsc_state_type;
endpackage : tsc_pkg

// ---- hw/tsc_serial_cmd_parser.sv ----
// Purpose: Serial command interpreter of a 3D tracking control unit.
// Assumes: 125 MHz core clock; host link is an asynchronous serial line.
// Notes:   Registers sit on an Avalon-MM slave with waitrequest.
// Function
// - Every command is an asterisk followed by at least one more character.
// - Only reset and demand mode are accepted outside on-demand reporting.
// - Unknown characters and characters at the wrong rate are dropped.
// - Switch-to-2D enters mouse emulation at 1200 bps, 7N1.
// - Reset command reinitialises the unit in any reporting mode.
// - Demand mode stops automatic reports; reports only on request.
// - A report in flight when demand mode arrives is finished whole.
// - Single-report request sends the last valid report held.
// - Position refreshes every 20 ms; invalid tracking keeps old values.
// - Incremental mode reports while moving, at most 50 per second.
// - Stream mode reports 50 per second regardless of motion.
// - Diagnostics reply is two bytes with fixed top-bit markers.
// - Result bits ordered unit, cpu, rom, ram, tx, rx, serial, nvm.
// - One means pass; all pass with reserved bits gives BF 3F.
// - Speaker-enable turns the speaker on; it is on by default.
// - Speaker-disable turns the speaker off until re-enabled.
// - Information command returns thirty bytes with marked first byte.
// - Mode byte flags incremental bit 0, demand bit 1, stream bit 2.
// - Receiver kind byte reports the connected receiver code.
// - Transmitter kind byte reports the connected transmitter code.
// - Bytes 11-21 geometry low first, button flag byte 15, rest zero.
// - 3D link is 19200 bps 8N1; initialisation sends nothing back.
// - Every data report is sixteen bytes long.
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "tsc_consts.svh"

module tsc_serial_cmd_parser #(
  parameter int unsigned BIT_CYC_3D  = `TSC_BIT_CYC_3D,
  parameter int unsigned BIT_CYC_2D  = `TSC_BIT_CYC_2D,
  parameter int unsigned REFRESH_CYC = `TSC_REFRESH_CYC
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    resetn_i,
  input  wire logic [7:0]              avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic                         avs_waitrequest_o,
  output logic [31:0]                  avs_readdata_o,
  input  wire logic                    uart_rx_i,
  output logic                         uart_tx_o,
  input  wire tsc_pkg::tsc_report_type report_data_i,
  input  wire logic                    report_valid_i,
  output logic                         speaker_en_o,
  output logic                         mode_2d_o,
  output logic                         sw_reset_o
);
  import tsc_pkg::*;

  tsc_state_type s_q;
  tsc_state_type s_d;
  logic [23:0]   bit_full;
  logic [3:0]    nbits;
  logic          rx_ok;
  logic [7:0]    rx_byte;
  logic          changed;
  logic [4:0]    len;
  logic [31:0]   rd_word;

  // One-hot report mode flags, shared by the status word and info byte.
  function automatic logic [2:0] tsc_flags(tsc_mode_type m);
    case (m)
      TSC_INCR:   return `TSC_RM_INCR;
      TSC_STREAM: return `TSC_RM_STREAM;
      default:    return `TSC_RM_DEMAND;
    endcase
  endfunction : tsc_flags

  // Merge write data into a register under the byte enables.
  function automatic logic [31:0] tsc_merge(logic [31:0] old,
                                            logic [31:0] wd,
                                            logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : tsc_merge

  // Byte i (from zero) of the answer of kind k.
  // Reports go out byte 1 first; info bytes follow a fixed layout.
  function automatic logic [7:0] tsc_byte(tsc_resp_type k,
                                          logic [4:0] i,
                                          tsc_state_type s);
    logic [7:0] r;
    r = 8'h00;
    if (k == RESP_REPORT) begin
      r = s.held[(15 - int'(i)) * 8 +: 8];
    end else if (k == RESP_DIAG) begin
      // Top four result bits are reserved and always report pass.
      if (i == 5'h00) begin
        r = {2'b10, s.diag[5:0]};
      end else begin
        r = {2'b00, 4'hf, s.diag[7:6]};
      end
    end else begin
      case (i)
        5'h00:   r = {2'b10, s.info[5:0]};
        5'h01:   r = `TSC_DIM_3D;
        5'h02:   r = {5'h00, tsc_flags(s.mode)};
        5'h03:   r = `TSC_DATA_TYPE;
        5'h04:   r = `TSC_REC_SIZE;
        5'h05:   r = `TSC_TRACK_MODE;
        5'h06:   r = {6'h00, s.info[25:24]};
        5'h07:   r = {7'h00, s.spk_on};
        5'h08:   r = {1'b0, s.info[14:8]};
        5'h09:   r = {1'b0, s.info[22:16]};
        5'h0a:   r = s.span0[7:0];
        5'h0b:   r = s.span0[15:8];
        5'h0c:   r = s.span0[23:16];
        5'h0d:   r = s.span0[31:24];
        5'h0e:   r = {7'h00, s.info[28]};
        5'h0f:   r = s.span1[7:0];
        5'h10:   r = s.span1[15:8];
        5'h11:   r = s.span1[23:16];
        5'h12:   r = s.span1[31:24];
        5'h13:   r = s.span2[7:0];
        5'h14:   r = s.span2[15:8];
        default: r = 8'h00;
      endcase
    end
    return r;
  endfunction : tsc_byte

  // Next-state logic for the whole block.
  always_comb begin
    s_d      = s_q;
    rx_ok    = 1'b0;
    changed  = 1'b0;
    rd_word  = 32'h0000_0000;
    // Line rate and frame width follow the active dimension.
    bit_full = s_q.dim_2d ? 24'(BIT_CYC_2D - 1)
                          : 24'(BIT_CYC_3D - 1);
    nbits    = s_q.dim_2d ? `TSC_NBITS_2D : `TSC_NBITS_3D;
    rx_byte  = s_q.dim_2d ? {1'b0, s_q.rx_sh[7:1]} : s_q.rx_sh;
    case (s_q.resp)
      RESP_DIAG: len = `TSC_LEN_DIAG;
      RESP_INFO: len = `TSC_LEN_INFO;
      default:   len = `TSC_LEN_REPORT;
    endcase
    // The software reset strobe is a one-cycle pulse.
    s_d.sw_rst = 1'b0;

    // Two-stage synchroniser on the receive pin.
    s_d.rx_s1 = uart_rx_i;
    s_d.rx_s2 = s_q.rx_s1;

    // Receiver: centre-sampled frames, checked start and stop bits.
    // In 2D the seven data bits end up in the top of the shifter.
    if (s_q.rx_cnt != 24'h0) begin
      s_d.rx_cnt = s_q.rx_cnt - 24'h1;
    end
    case (s_q.rx_st)
      RX_IDLE: begin
        if (!s_q.rx_s2) begin
          s_d.rx_st  = RX_START;
          s_d.rx_cnt = {1'b0, bit_full[23:1]};
        end
      end
      RX_START: begin
        if (s_q.rx_cnt == 24'h0) begin
          if (!s_q.rx_s2) begin
            s_d.rx_st  = RX_DATA;
            s_d.rx_cnt = bit_full;
            s_d.rx_bit = 4'h0;
          end else begin
            s_d.rx_st = RX_IDLE;
          end
        end
      end
      RX_DATA: begin
        if (s_q.rx_cnt == 24'h0) begin
          s_d.rx_sh  = {s_q.rx_s2, s_q.rx_sh[7:1]};
          s_d.rx_bit = s_q.rx_bit + 4'h1;
          s_d.rx_cnt = bit_full;
          if (s_q.rx_bit == nbits - 4'h1) begin
            s_d.rx_st = RX_STOP;
          end
        end
      end
      default: begin
        // A missing stop bit means the wrong rate: the byte is lost.
        if (s_q.rx_cnt == 24'h0) begin
          s_d.rx_st = RX_IDLE;
          rx_ok     = s_q.rx_s2;
        end
      end
    endcase

    // Refresh tick: latch only valid tracking data, else keep old.
    // The counter starts at zero, so the first sample follows reset.
    if (s_q.tick_cnt == 24'h0) begin
      s_d.tick_cnt = 24'(REFRESH_CYC - 1);
      if (report_valid_i) begin
        changed  = (s_q.held != report_data_i);
        s_d.held = report_data_i;
      end
      // A report still going out skips this tick, capping the rate.
      if (!s_q.dim_2d && s_q.resp == RESP_NONE &&
          (s_q.mode == TSC_STREAM ||
           (s_q.mode == TSC_INCR && changed))) begin
        s_d.resp = RESP_REPORT;
        s_d.idx  = 5'h00;
      end
    end else begin
      s_d.tick_cnt = s_q.tick_cnt - 24'h1;
    end

    // Answer sequencer: hands bytes to the transmitter one at a time.
    // Only the reset and switch-to-2D commands stop it; mode commands let a report go out whole.
    if (!s_q.tx_busy && s_q.resp != RESP_NONE) begin
      s_d.tx_busy = 1'b1;
      s_d.tx_line = 1'b0;
      s_d.tx_sh   = {1'b1, tsc_byte(s_q.resp, s_q.idx, s_q)};
      // A 7-bit frame takes its stop bit from bit 7 of the shifter.
      if (s_q.dim_2d) begin
        s_d.tx_sh[7] = 1'b1;
      end
      s_d.tx_bits = nbits + 4'h1;
      s_d.tx_cnt  = bit_full;
      if (s_q.idx == len - 5'h01) begin
        s_d.resp = RESP_NONE;
        s_d.idx  = 5'h00;
      end else begin
        s_d.idx = s_q.idx + 5'h01;
      end
    end else if (s_q.tx_busy) begin
      if (s_q.tx_cnt != 24'h0) begin
        s_d.tx_cnt = s_q.tx_cnt - 24'h1;
      end else if (s_q.tx_bits == 4'h0) begin
        s_d.tx_busy = 1'b0;
      end else begin
        s_d.tx_line = s_q.tx_sh[0];
        s_d.tx_sh   = {1'b1, s_q.tx_sh[8:1]};
        s_d.tx_bits = s_q.tx_bits - 4'h1;
        s_d.tx_cnt  = bit_full;
      end
    end

    // Command parser; in 2D mode this command set is not interpreted.
    if (rx_ok && !s_q.dim_2d) begin
      s_d.got_star = (rx_byte == `TSC_STAR);
      if (s_q.got_star) begin
        if (rx_byte == `TSC_CMD_RESET) begin
          // Reinitialise quietly; nothing is sent back.
          s_d.mode     = TSC_DEMAND;
          s_d.spk_on   = 1'b1;
          s_d.resp     = RESP_NONE;
          s_d.idx      = 5'h00;
          s_d.got_star = 1'b0;
          s_d.sw_rst   = 1'b1;
        end else if (rx_byte == `TSC_CMD_DEMAND) begin
          s_d.mode = TSC_DEMAND;
        end else if (s_q.mode == TSC_DEMAND) begin
          case (rx_byte)
            `TSC_CMD_TO_2D: begin
              s_d.dim_2d   = 1'b1;
              s_d.got_star = 1'b0;
              // Queued answers would go out at the new rate: drop them.
              // A byte already on the line ends at the new bit time.
              s_d.resp     = RESP_NONE;
              s_d.idx      = 5'h00;
            end
            `TSC_CMD_SINGLE: begin
              if (s_q.resp == RESP_NONE) begin
                s_d.resp = RESP_REPORT;
                s_d.idx  = 5'h00;
              end
            end
            `TSC_CMD_INCR:   s_d.mode = TSC_INCR;
            `TSC_CMD_STREAM: s_d.mode = TSC_STREAM;
            `TSC_CMD_DIAG: begin
              if (s_q.resp == RESP_NONE) begin
                s_d.resp = RESP_DIAG;
                s_d.idx  = 5'h00;
              end
            end
            `TSC_CMD_SPK_ON:  s_d.spk_on = 1'b1;
            `TSC_CMD_SPK_OFF: s_d.spk_on = 1'b0;
            `TSC_CMD_INFO: begin
              if (s_q.resp == RESP_NONE) begin
                s_d.resp = RESP_INFO;
                s_d.idx  = 5'h00;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end

    // Read mux; unmapped addresses read as zero.
    // Status: [2:0] mode flags, [3] speaker, [4] 2D, [5] transmitter
    // busy, [6] answer pending.
    if (avs_address_i == `TSC_OFF_STATUS) begin
      rd_word = {25'h0, s_q.resp != RESP_NONE, s_q.tx_busy,
                 s_q.dim_2d, s_q.spk_on, tsc_flags(s_q.mode)};
    end else if (avs_address_i == `TSC_OFF_DIAG) begin
      rd_word = {24'h0, s_q.diag};
    end else if (avs_address_i == `TSC_OFF_INFO) begin
      rd_word = s_q.info;
    end else if (avs_address_i == `TSC_OFF_SPAN0) begin
      rd_word = s_q.span0;
    end else if (avs_address_i == `TSC_OFF_SPAN1) begin
      rd_word = s_q.span1;
    end else if (avs_address_i == `TSC_OFF_SPAN2) begin
      rd_word = s_q.span2;
    end

    // Bus slave: one wait cycle, then the access completes.
    // The write lands at the edge where the master sees waitrequest low,
    // and waitrequest rises there, so a stalled master writes only once.
    s_d.waitreq = 1'b1;
    if ((avs_read_i || avs_write_i) && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.rdata   = avs_read_i ? rd_word : 32'h0000_0000;
    end
    if (avs_write_i && !s_q.waitreq) begin
      if (avs_address_i == `TSC_OFF_DIAG) begin
        s_d.diag = 8'(tsc_merge({24'h0, s_q.diag}, avs_writedata_i,
                                avs_byteenable_i));
      end else if (avs_address_i == `TSC_OFF_INFO) begin
        s_d.info = tsc_merge(s_q.info, avs_writedata_i,
                             avs_byteenable_i);
      end else if (avs_address_i == `TSC_OFF_SPAN0) begin
        s_d.span0 = tsc_merge(s_q.span0, avs_writedata_i,
                              avs_byteenable_i);
      end else if (avs_address_i == `TSC_OFF_SPAN1) begin
        s_d.span1 = tsc_merge(s_q.span1, avs_writedata_i,
                              avs_byteenable_i);
      end else if (avs_address_i == `TSC_OFF_SPAN2) begin
        s_d.span2 = tsc_merge(s_q.span2, avs_writedata_i,
                              avs_byteenable_i);
      end
    end
  end

  // State register; idle lines and the speaker come up high.
  // Registers and the held report survive the software reset; only the
  // power-on reset restores their reset values.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q         <= '0;
      s_q.rx_s1   <= 1'b1;
      s_q.rx_s2   <= 1'b1;
      s_q.spk_on  <= 1'b1;
      s_q.tx_line <= 1'b1;
      s_q.waitreq <= 1'b1;
      s_q.diag    <= `TSC_DIAG_RST;
      s_q.info    <= `TSC_INFO_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign avs_waitrequest_o = s_q.waitreq;
  assign avs_readdata_o    = s_q.rdata;
  assign uart_tx_o         = s_q.tx_line;
  assign speaker_en_o      = s_q.spk_on;
  assign mode_2d_o         = s_q.dim_2d;
  assign sw_reset_o        = s_q.sw_rst;

endmodule : tsc_serial_cmd_parser

// ---- tb/tsc_host_model.sv ----
// Purpose: Host computer on the far end of the serial link.
// Assumes: 8N1 framing at BIT cycles a bit; line idles high.
// Notes:   Received bytes queue up in rxq for the bench.
`timescale 1ns/1ns
module tsc_host_model #(
  parameter int unsigned BIT = 16,
  parameter int unsigned GAP = 200
) (
  input  wire logic core_clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  logic [7:0] rxq[$];
  initial line_o = 1'b1;
  // One frame: start, eight data bits LSB first, stop.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      repeat (BIT) @(posedge core_clk_i);
    end
  endtask : send_byte
  // Every command goes out with the asterisk in front.
  task automatic send_cmd(input logic [7:0] c);
    send_byte(8'h2a);
    send_byte(c);
  endtask : send_cmd
  // Scaled quiet time after a software reset before the next command.
  task automatic settle();
    repeat (GAP) @(posedge core_clk_i);
  endtask : settle
  // Receiver samples on the falling clock so it never races the edge.
  always begin : rx
    logic [7:0] b;
    @(negedge core_clk_i);
    if (line_i === 1'b0) begin
      repeat (BIT / 2) @(negedge core_clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(negedge core_clk_i);
        b[i] = line_i;
      end
      repeat (BIT) @(negedge core_clk_i);
      rxq.push_back(b);
    end
  end
endmodule : tsc_host_model

// ---- tb/tsc_serial_cmd_parser_properties.sv ----
// Purpose: Temporal checks on the command parser's ports.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Bound to every instance of the parser.
`timescale 1ns/1ns
module tsc_serial_cmd_parser_properties (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        uart_tx_o,
  input wire logic        speaker_en_o,
  input wire logic        mode_2d_o,
  input wire logic        sw_reset_o
);
  logic unmapped;
  logic req;
  // Addresses outside the six word registers answer with zero.
  assign unmapped = (avs_address_i > 8'h14) || (avs_address_i[1:0] != 2'h0);
  assign req = avs_read_i || avs_write_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  a_bus_answer: assert property (
    req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("Bus request not answered in one cycle");
  a_bus_one_low: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("Answer cycle longer than one cycle");
  a_bus_cause: assert property (!avs_waitrequest_o |-> $past(req))
    else $error("Answer without a request");
  a_unmapped_zero: assert property (avs_read_i && avs_waitrequest_o && unmapped
    |=> avs_readdata_o == 32'h0) else $error("Unmapped read not zero");
  a_init_quiet: assert property ($rose(resetn_i) |-> uart_tx_o [*8])
    else $error("Line active right after reset");
  a_line_bit_time: assert property (
    $fell(uart_tx_o) |-> !uart_tx_o [*8])
    else $error("Low bit shorter than half a bit time");
  a_reset_pulse: assert property (sw_reset_o |=> !sw_reset_o)
    else $error("Reset pulse longer than one cycle");
  a_reset_speaker: assert property (sw_reset_o |-> ##2 speaker_en_o)
    else $error("Speaker not on after software reset");
  a_2d_sticky: assert property (mode_2d_o |=> mode_2d_o)
    else $error("Left mouse emulation without reset");
  a_2d_quiet: assert property (mode_2d_o && uart_tx_o |=> uart_tx_o)
    else $error("Transmission in mouse emulation");
  c_sw_reset: cover property (sw_reset_o);
  c_spk_off: cover property ($fell(speaker_en_o));
  c_enter_2d: cover property ($rose(mode_2d_o));
endmodule : tsc_serial_cmd_parser_properties

bind tsc_serial_cmd_parser tsc_serial_cmd_parser_properties i_props (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .avs_readdata_o(avs_readdata_o),
  .uart_tx_o(uart_tx_o), .speaker_en_o(speaker_en_o), .mode_2d_o(mode_2d_o),
  .sw_reset_o(sw_reset_o));

// ---- tb/tsc_serial_cmd_parser_tb.sv ----
// Purpose: Self-checking bench of the serial command parser.
// Assumes: Bit time 16 cycles and refresh 4000 cycles to keep runs short.
// Notes:   Refresh exceeds one 16-byte report time, as stream mode needs.
`timescale 1ns/1ns
module tsc_serial_cmd_parser_tb;
  import tsc_pkg::*;
  localparam int unsigned REF = 4000;
  localparam logic [127:0] R1 = 128'h8102030405060708090a0b0c0d0e0f10;
  localparam logic [127:0] R2 = 128'h80112233445566770011223344556677;
  localparam logic [239:0] INFO =
    240'hbf020201100102000e0d11223344015566778899aa000000000000000000;
  logic           core_clk;
  logic           resetn;
  logic [7:0]     addr;
  logic           rd;
  logic           wr;
  logic [31:0]    wdata;
  logic [3:0]     be;
  logic           waitreq;
  logic [31:0]    rdata;
  logic           rx_line;
  logic           tx_line;
  tsc_report_type rep;
  logic           rep_ok;
  logic           spk;
  logic           m2d;
  logic           swr;
  logic           swr_seen;
  logic [31:0]    q;
  logic [7:0]     b;
  int             mismatches;
  int             num_checks;

  tsc_serial_cmd_parser #(.BIT_CYC_3D(16), .BIT_CYC_2D(32),
    .REFRESH_CYC(REF)) i_dut (
    .core_clk_i(core_clk), .resetn_i(resetn), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_waitrequest_o(waitreq),
    .avs_readdata_o(rdata), .uart_rx_i(rx_line), .uart_tx_o(tx_line),
    .report_data_i(rep), .report_valid_i(rep_ok), .speaker_en_o(spk),
    .mode_2d_o(m2d), .sw_reset_o(swr));
  tsc_host_model #(.BIT(16), .GAP(200)) i_host (
    .core_clk_i(core_clk), .line_i(tx_line), .line_o(rx_line));

  // Free-running 125 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Latch any software reset pulse, which lasts only one cycle.
  always @(posedge core_clk) if (swr === 1'b1) swr_seen <= 1'b1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon access; holds everything until waitrequest is seen low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    // Sampled at the rising edge; read data is taken at that same edge.
    do begin
      @(posedge core_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // One idle edge, so a following call never re-raises a strobe at once.
    @(posedge core_clk);
    if (n == 50) mismatches++;
  endtask : bus
  task automatic cmd(input logic [7:0] c);
    i_host.send_cmd(c);
    repeat (4) @(posedge core_clk);
  endtask : cmd
  // Waits a bounded time for one received byte.
  task automatic get_byte(output logic [7:0] v);
    int n;
    n = 0;
    while (i_host.rxq.size() == 0 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    v = 8'h0;
    if (n == 20000) mismatches++;
    else v = i_host.rxq.pop_front();
  endtask : get_byte
  task automatic expect_bytes(input logic [239:0] v, input int cnt);
    logic [7:0] g;
    for (int i = 0; i < cnt; i++) begin
      get_byte(g);
      chk(32'(g), 32'(v[239-8*i -: 8]));
    end
  endtask : expect_bytes
  task automatic summarize();
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // Main sequence of command scenarios.
  initial begin
    resetn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    be = 4'hf;
    rep = '0;
    rep_ok = 1'b0;
    swr_seen = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk(32'(spk), 32'h1);
    chk(32'(m2d), 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0a);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    cmd(8'h05);
    expect_bytes({16'hbf3f, 224'h0}, 2);
    bus(1'b1, 8'h04, 32'h01);
    cmd(8'h05);
    expect_bytes({16'h813c, 224'h0}, 2);
    cmd(8'h4f);
    chk(32'(spk), 32'h0);
    bus(1'b1, 8'h08, 32'h120d0e3f);
    bus(1'b1, 8'h0c, 32'h44332211);
    bus(1'b1, 8'h10, 32'h88776655);
    bus(1'b1, 8'h14, 32'h0000aa99);
    cmd(8'h6d);
    expect_bytes(INFO, 30);
    cmd(8'h41);
    chk(32'(spk), 32'h1);
    rep <= R1;
    rep_ok <= 1'b1;
    repeat (REF + 100) @(posedge core_clk);
    cmd(8'h64);
    expect_bytes({R1, 112'h0}, 16);
    rep_ok <= 1'b0;
    rep <= R2;
    repeat (REF + 100) @(posedge core_clk);
    cmd(8'h64);
    expect_bytes({R1, 112'h0}, 16);
    i_host.send_byte(8'h05);
    cmd(8'h7a);
    repeat (400) @(posedge core_clk);
    chk(32'(i_host.rxq.size()), 32'h0);
    rep <= R1;
    rep_ok <= 1'b1;
    cmd(8'h49);
    cmd(8'h6d);
    repeat (2 * REF) @(posedge core_clk);
    chk(32'(i_host.rxq.size()), 32'h0);
    rep <= R2;
    expect_bytes({R2, 112'h0}, 16);
    cmd(8'h44);
    cmd(8'h53);
    expect_bytes({R2, 112'h0}, 16);
    get_byte(b);
    chk(32'(b), 32'(R2[127:120]));
    i_host.send_cmd(8'h44);
    expect_bytes({R2[119:0], 120'h0}, 15);
    repeat (2 * REF) @(posedge core_clk);
    chk(32'(i_host.rxq.size()), 32'h0);
    cmd(8'h53);
    cmd(8'h52);
    repeat (3000) @(posedge core_clk);
    chk(32'(swr_seen), 32'h1);
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0a);
    i_host.rxq.delete();
    i_host.settle();
    cmd(8'h3c);
    chk(32'(m2d), 32'h1);
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h1a);
    cmd(8'h05);
    repeat (600) @(posedge core_clk);
    chk(32'(i_host.rxq.size()), 32'h0);
    summarize();
  end
  // Watchdog: the whole sequence needs well under this many cycles.
  initial begin
    repeat (95000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
endmodule : tsc_serial_cmd_parser_tb
